// ### logic/hbp_pkg.sv
package hbp_pkg;
  // ****************************************
  // Address map and widths
  // ****************************************
  localparam int HBP_ADDR_W = 13;
  localparam int HBP_RAM_WORDS = 4096;
  localparam int HBP_REG_WORDS = 16;
  localparam logic [12:0] HBP_RAM_LAST_BYTE = 13'h1fff;
  localparam logic [12:0] HBP_REG_LAST_BYTE = 13'h001f;
  localparam logic HBP_LANE_LOW = 1'b0;
  localparam logic HBP_LANE_HIGH = 1'b1;
  localparam logic HBP_SPACE_RAM = 1'b1;
  localparam logic HBP_SPACE_REG = 1'b0;

  // ****************************************
  // Clock frequency codes
  // ****************************************
  typedef enum logic [1:0] {HBP_F10, HBP_F12, HBP_F16, HBP_F20} hbp_freq_e;
  localparam logic [1:0] HBP_FREQ_RESET = 2'h2;
  localparam int HBP_CFG5_IDX = 5;
  localparam int HBP_CFG6_IDX = 6;
  localparam int HBP_CFG5_FREQ_BIT = 15;
  localparam int HBP_CFG6_FREQ_BIT = 15;

  // ****************************************
  // Operating modes and word-to-word delays
  // ****************************************
  typedef enum logic [1:0] {HBP_MODE_MASTER, HBP_MODE_RESPONDER, HBP_MODE_WORDMON, HBP_MODE_MSGMON} hbp_mode_e;
  localparam int HBP_CLK_MHZ = 20;
  // Delay in ns, indexed [mode][freq 10/12/16/20]
  localparam int HBP_DELAY_NS [4][4] = '{
    '{3800, 3100, 2400, 1900},
    '{7700, 6400, 4900, 3900},
    '{1800, 1500, 1100, 900},
    '{4200, 3500, 2600, 2100}};
  localparam int HBP_CLK_NS = 1000 / HBP_CLK_MHZ;
  localparam logic [1:0] HBP_SETTLE_CYC = 2'h2;
endpackage

// ### logic/hbp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hbp_if;
  logic sel_n;
  logic host_strobe_n;
  logic rd_wr;
  logic space_sel;
  logic host_byte_lane_bit;
  logic [12:0] addr;
  logic [7:0] d_host;
  logic [7:0] d_dev;
  logic d_dev_oe;
  logic transfer_done_n;
  logic upper_addr_enable_strap;
  logic freq_pick_2;
  logic freq_pick_0;
  logic rx_pos;
  modport dev (input sel_n, host_strobe_n, rd_wr, space_sel, host_byte_lane_bit, addr, d_host,
    upper_addr_enable_strap, freq_pick_2, freq_pick_0, rx_pos,
    output d_dev, d_dev_oe, transfer_done_n);
  modport host (output sel_n, host_strobe_n, rd_wr, space_sel, host_byte_lane_bit, addr, d_host,
    upper_addr_enable_strap, freq_pick_2, freq_pick_0,
    input d_dev, d_dev_oe, transfer_done_n);
endinterface
`default_nettype wire

// ### logic/hbp_host.sv
`timescale 1ns/100ps
`default_nettype none
module hbp_host
  import hbp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  hbp_if.host bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ****************************************
  // Own registers: 0x00 cmd, 0x04 addr, 0x08 data, 0x0c status, 0x10 config
  // ****************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_CFG = 8'h10;

  typedef enum logic [2:0] {ST_IDLE, ST_STROBE, ST_RELEASE, ST_WAITDONE, ST_GAP} hbp_hst_e;
  typedef struct packed {
    hbp_hst_e st;
    logic [2:0] step;
    logic is_read;
    logic space;
    logic [11:0] word;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic busy;
    logic [1:0] mode;
    logic [1:0] freq;
    logic [1:0] strap;
    logic [8:0] gap;
    logic sel_n;
    logic strb_n;
    logic lane;
    logic [7:0] dout;
    logic [1:0] done_sync;
    logic [7:0] din;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } hbp_hst_s;
  hbp_hst_s q, d;

  function automatic logic [8:0] gap_cycles(input logic [1:0] m, input logic [1:0] f);
    gap_cycles = 9'((HBP_DELAY_NS[m][f] + HBP_CLK_NS - 1) / HBP_CLK_NS);
  endfunction

  always_comb
  begin
    d = q;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.done_sync = {q.done_sync[0], bus.transfer_done_n};
    d.din = bus.d_dev;
    if (psel && penable && !q.pready)
    begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      unique case (paddr[7:0])
        OFS_CMD:
          if (pwrite && !q.busy)
          begin
            d.is_read = pwdata[0];
            d.space = pwdata[1];
            d.busy = 1'b1;
            d.step = 3'h0;
            d.st = ST_STROBE;
          end
        OFS_ADDR:
          if (pwrite) d.word = pwdata[11:0];
          else d.prdata = {20'h0_0000, q.word};
        OFS_DATA:
          if (pwrite) d.wdata = pwdata[15:0];
          else d.prdata = {16'h0000, q.rdata};
        OFS_STAT:
          d.prdata = {30'h0, ~q.done_sync[1], q.busy};
        OFS_CFG:
          if (pwrite)
          begin
            d.mode = pwdata[1:0];
            d.freq = pwdata[3:2];
            d.strap = pwdata[5:4];
          end
          else d.prdata = {26'h0, q.strap, q.freq, q.mode};
        default: d.pslverr = 1'b1;
      endcase
    end
    unique case (q.st)
      ST_IDLE: ;
      ST_STROBE:
      begin
        // Byte sequence: write lo,hi; read dummy hi, lo, hi
        d.sel_n = 1'b0;
        d.strb_n = 1'b0;
        if (q.is_read)
          d.lane = (q.step == 3'h1) ? HBP_LANE_LOW : HBP_LANE_HIGH;
        else
          d.lane = (q.step == 3'h0) ? HBP_LANE_LOW : HBP_LANE_HIGH;
        d.dout = (q.step == 3'h0) ? q.wdata[7:0] : q.wdata[15:8];
        d.st = ST_RELEASE;
      end
      ST_RELEASE:
      begin
        d.strb_n = 1'b1;
        d.st = ST_WAITDONE;
      end
      ST_WAITDONE:
        if (!q.done_sync[1])
        begin
          d.sel_n = 1'b1;
          if (q.is_read && q.step == 3'h1) d.rdata[7:0] = q.din;
          if (q.is_read && q.step == 3'h2) d.rdata[15:8] = q.din;
          d.step = q.step + 3'h1;
          if (q.is_read && q.step == 3'h0)
          begin
            d.gap = gap_cycles(q.mode, q.freq);
            d.st = ST_GAP;
          end
          else if ((q.is_read && q.step == 3'h2) || (!q.is_read && q.step == 3'h1))
          begin
            d.gap = gap_cycles(q.mode, q.freq);
            d.st = ST_GAP;
          end
          else d.st = ST_STROBE;
        end
      ST_GAP:
        if (q.gap == 9'h000)
        begin
          if (q.is_read && q.step == 3'h1) d.st = ST_STROBE;
          else
          begin
            d.busy = 1'b0;
            d.st = ST_IDLE;
          end
        end
        else d.gap = q.gap - 9'h001;
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.freq <= HBP_FREQ_RESET;
      q.sel_n <= 1'b1;
      q.strb_n <= 1'b1;
      q.done_sync <= 2'b11;
    end
    else q <= d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus.sel_n = q.sel_n;
  assign bus.host_strobe_n = q.strb_n;
  assign bus.rd_wr = q.is_read;
  assign bus.space_sel = q.space;
  assign bus.host_byte_lane_bit = q.lane;
  assign bus.addr = {q.word, q.lane};
  assign bus.d_host = q.dout;
  assign bus.upper_addr_enable_strap = q.strap[1];
  assign bus.freq_pick_2 = q.freq[1];
  assign bus.freq_pick_0 = q.freq[0];
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
endmodule // hbp_host
`default_nettype wire

// ### logic/hbp_dev.sv
`timescale 1ns/100ps
`default_nettype none
module hbp_dev
  import hbp_pkg::*;
#(
  parameter int RAM_WORDS = HBP_RAM_WORDS
)
(
  input wire logic pclk,
  input wire logic presetn,
  hbp_if.dev bus,
  input wire logic cfg_we,
  input wire logic [3:0] cfg_idx,
  input wire logic [15:0] cfg_wdata,
  output logic [1:0] freq_sel,
  output logic [15:0] rx_samples
);
  typedef struct packed {
    logic [1:0] sel_s1, sel_s2;
    logic [1:0] strb_s1, strb_s2;
    logic strb_last;
    logic [1:0] rx_s;
    logic rx_neg;
    logic [15:0] rx_sh;
    logic [7:0] hold;
    logic [15:0] rd_word;
    logic [7:0] dout;
    logic oe;
    logic done_n;
    logic [1:0] freq;
    logic strap_taken;
  } hbp_dev_s;
  hbp_dev_s q, d;

  logic [15:0] ram_q [RAM_WORDS];
  logic [15:0] reg_q [HBP_REG_WORDS];
  logic rx_neg_q;
  logic rx_neg_s1_q;
  logic [1:0] strb_sync;
  logic [1:0] sel_sync;
  logic [1:0] cfg_sync;
  logic trig, rd_tr, wr_tr;
  logic [11:0] widx;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strb_sync <= 2'b11;
      sel_sync <= 2'b11;
      cfg_sync <= 2'b00;
    end
    else
    begin
      strb_sync <= {strb_sync[0], bus.host_strobe_n};
      sel_sync <= {sel_sync[0], bus.sel_n};
      cfg_sync <= {cfg_sync[0], bus.upper_addr_enable_strap};
    end
  end

  // Falling-edge receiver sample, two stages before use
  always_ff @(negedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_neg_s1_q <= 1'b0;
      rx_neg_q <= 1'b0;
    end
    else
    begin
      rx_neg_s1_q <= bus.rx_pos;
      rx_neg_q <= rx_neg_s1_q;
    end
  end

  assign trig = q.strb_last == 1'b0 && strb_sync[1] && !sel_sync[1];
  assign rd_tr = trig && bus.rd_wr;
  assign wr_tr = trig && !bus.rd_wr;
  assign widx = bus.addr[12:1];

  always_comb
  begin
    d = q;
    d.strb_last = strb_sync[1];
    d.rx_s = {q.rx_s[0], bus.rx_pos};
    d.rx_sh = {q.rx_sh[13:0], q.rx_s[1], rx_neg_q};
    d.oe = !sel_sync[1] && !strb_sync[1] && bus.rd_wr;
    d.done_n = !trig;
    if (wr_tr && bus.host_byte_lane_bit == HBP_LANE_LOW)
      d.hold = bus.d_host;
    if (rd_tr && bus.host_byte_lane_bit == HBP_LANE_HIGH)
    begin
      // Triggering read fetches whole word, low byte kept
      if (bus.space_sel == HBP_SPACE_RAM) d.rd_word = ram_q[widx];
      else d.rd_word = reg_q[widx[3:0]];
    end
    if (!sel_sync[1])
      d.dout = (bus.host_byte_lane_bit == HBP_LANE_HIGH) ? q.rd_word[15:8] : q.rd_word[7:0];
    if (cfg_we && cfg_idx == 4'(HBP_CFG5_IDX)) d.freq[1] = cfg_wdata[HBP_CFG5_FREQ_BIT];
    if (cfg_we && cfg_idx == 4'(HBP_CFG6_IDX)) d.freq[0] = cfg_wdata[HBP_CFG6_FREQ_BIT];
    if (cfg_sync[1] && !q.strap_taken && RAM_WORDS == HBP_RAM_WORDS)
    begin
      d.freq = {bus.freq_pick_2, bus.freq_pick_0};
      d.strap_taken = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.strb_last <= 1'b1;
      q.done_n <= 1'b1;
      q.freq <= HBP_FREQ_RESET;
    end
    else q <= d;
  end

  // Storage written only on triggering upper byte
  always_ff @(posedge pclk)
  begin
    if (wr_tr && bus.host_byte_lane_bit == HBP_LANE_HIGH)
    begin
      if (bus.space_sel == HBP_SPACE_RAM) ram_q[widx] <= {bus.d_host, q.hold};
      else reg_q[widx[3:0]] <= {bus.d_host, q.hold};
    end
  end

  assign bus.d_dev = q.dout;
  assign bus.d_dev_oe = q.oe;
  assign bus.transfer_done_n = q.done_n;
  assign freq_sel = q.freq;
  assign rx_samples = q.rx_sh;
endmodule // hbp_dev
`default_nettype wire

// ### bench/hbp_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module hbp_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sel_n,
  input wire logic host_strobe_n,
  input wire logic rd_wr,
  input wire logic space_sel,
  input wire logic host_byte_lane_bit,
  input wire logic [12:0] addr,
  input wire logic d_dev_oe,
  input wire logic transfer_done_n
);
  localparam int MIN_GAP = 16;
  logic prev_lane_q;
  logic prev_rd_q;
  logic armed_q;
  logic [7:0] gap_q;

  // ****************************************
  // Helper state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_lane_q <= 1'b0;
      prev_rd_q <= 1'b0;
      armed_q <= 1'b0;
      gap_q <= 8'h00;
    end
    else
    begin
      if ($rose(host_strobe_n))
      begin
        prev_lane_q <= host_byte_lane_bit;
        prev_rd_q <= rd_wr;
      end
      if (!transfer_done_n && host_byte_lane_bit)
      begin
        armed_q <= 1'b1;
        gap_q <= 8'h00;
      end
      else if (gap_q != 8'hff)
      begin
        gap_q <= gap_q + 8'h01;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence strobe_end_s;
    $rose(host_strobe_n) && !sel_n;
  endsequence
  sequence done_s;
    !transfer_done_n;
  endsequence

  sel_strobe_a: assert property (!host_strobe_n |-> !sel_n) else $error("strobe without select");
  done_pulse_a: assert property (done_s |=> transfer_done_n) else $error("done longer than one cycle");
  done_latency_a: assert property (strobe_end_s |-> ##[1:6] done_s) else $error("done too late");
  no_early_strobe_a: assert property (strobe_end_s |-> host_strobe_n [*4])
    else $error("strobe before done");
  write_order_a: assert property ($fell(host_strobe_n) && !rd_wr && host_byte_lane_bit |->
    !prev_lane_q && !prev_rd_q) else $error("upper write without lower first");
  read_order_a: assert property ($fell(host_strobe_n) && rd_wr && !host_byte_lane_bit |->
    prev_lane_q && prev_rd_q) else $error("lower read without upper before");
  word_gap_a: assert property ($fell(host_strobe_n) && armed_q |-> gap_q >= MIN_GAP)
    else $error("word gap too short");
  addr_hold_a: assert property (!host_strobe_n |=> $stable(addr) && $stable(host_byte_lane_bit))
    else $error("address changed during byte");
  oe_read_a: assert property (d_dev_oe |-> rd_wr || $past(rd_wr)) else $error("data driven on write");
endmodule // hbp_monitor
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import hbp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cfg_we = 1'b0;
  logic [3:0] cfg_idx = 4'h0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic [1:0] freq_sel;
  logic [15:0] rx_samples;
  logic [31:0] v;
  logic e;
  logic [15:0] q;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;

  always #25 pclk = ~pclk;

  hbp_if u_hbp_if();
  hbp_host u_hbp_host(.pclk(pclk), .presetn(presetn), .bus(u_hbp_if), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  hbp_dev u_hbp_dev(.pclk(pclk), .presetn(presetn), .bus(u_hbp_if), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
    .cfg_wdata(cfg_wdata), .freq_sel(freq_sel), .rx_samples(rx_samples));
  hbp_monitor u_hbp_monitor(.pclk(pclk), .presetn(presetn), .sel_n(u_hbp_if.sel_n),
    .host_strobe_n(u_hbp_if.host_strobe_n), .rd_wr(u_hbp_if.rd_wr), .space_sel(u_hbp_if.space_sel),
    .host_byte_lane_bit(u_hbp_if.host_byte_lane_bit), .addr(u_hbp_if.addr), .d_dev_oe(u_hbp_if.d_dev_oe),
    .transfer_done_n(u_hbp_if.transfer_done_n));

  // ****************************************
  // Tasks
  // ****************************************
  task end_sim;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask

  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rq, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Sample settled answer mid-cycle, complete on next rising edge
    @(negedge pclk);
    while (pready !== 1'b1)
      @(negedge pclk);
    rq = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task word(input logic rd, input logic sp, input logic [11:0] wa, input logic [15:0] wd, output logic [15:0] rq);
    apb(1'b1, 32'h0000_0004, {20'h0_0000, wa}, v, e);
    if (!rd)
      apb(1'b1, 32'h0000_0008, {16'h0000, wd}, v, e);
    apb(1'b1, 32'h0000_0000, {30'h0, sp, rd}, v, e);
    v = 32'h0000_0001;
    while (v[0] !== 1'b0)
      apb(1'b0, 32'h0000_000C, 32'h0000_0000, v, e);
    apb(1'b0, 32'h0000_0008, 32'h0000_0000, v, e);
    rq = v[15:0];
  endtask

  task cfg(input logic [3:0] i, input logic [15:0] d);
    cfg_idx <= i;
    cfg_wdata <= d;
    cfg_we <= 1'b1;
    @(posedge pclk);
    cfg_we <= 1'b0;
    @(posedge pclk);
  endtask

  // ****************************************
  // Timeout
  // ****************************************
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_sim;
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    u_hbp_if.rx_pos = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("freq_sel", {30'h0, freq_sel}, 32'h0000_0002);
    check("sel_n", {31'h0, u_hbp_if.sel_n}, 32'h0000_0001);
    for (int f = 0; f < 4; f++)
    begin
      cfg(4'h5, {f[1], 15'h0000});
      cfg(4'h6, {f[0], 15'h0000});
      check("freq_sel", {30'h0, freq_sel}, f);
    end
    cfg(4'h5, 16'h0000);
    cfg(4'h6, 16'h0000);
    apb(1'b1, 32'h0000_0010, 32'h0000_002E, v, e);
    repeat (4) @(posedge pclk);
    check("strap freq", {30'h0, freq_sel}, 32'h0000_0003);
    apb(1'b0, 32'h0000_0010, 32'h0000_0000, v, e);
    check("host cfg", v & 32'h0000_003F, 32'h0000_002E);
    word(1'b0, HBP_SPACE_RAM, 12'h000, 16'ha55a, q);
    word(1'b0, HBP_SPACE_RAM, 12'hfff, 16'h1234, q);
    word(1'b0, HBP_SPACE_REG, 12'h00f, 16'h00c3, q);
    word(1'b1, HBP_SPACE_RAM, 12'h000, 16'h0000, q);
    check("ram first", {16'h0000, q}, 32'h0000_a55a);
    word(1'b1, HBP_SPACE_RAM, 12'hfff, 16'h0000, q);
    check("ram last", {16'h0000, q}, 32'h0000_1234);
    word(1'b1, HBP_SPACE_REG, 12'h00f, 16'h0000, q);
    check("reg last", {16'h0000, q}, 32'h0000_00c3);
    apb(1'b0, 32'h0000_0040, 32'h0000_0000, v, e);
    check("pslverr", {31'h0, e}, 32'h0000_0001);
    u_hbp_if.rx_pos <= 1'b1;
    repeat (12) @(posedge pclk);
    check("rx ones", {16'h0000, rx_samples}, 32'h0000_ffff);
    u_hbp_if.rx_pos <= 1'b0;
    repeat (12) @(posedge pclk);
    check("rx zeros", {16'h0000, rx_samples}, 32'h0000_0000);
    end_sim;
  end
endmodule // tb
`default_nettype wire
